// *** rtl/dmu_map.svh ***
// Functional notes
// - Signed divide: special opcode, zero field, func 011010
// - Unsigned divide: special opcode, zero field, func 011011
// - Multiply-add: special opcode, zero field, func 101001
// - Signed divide treats operands as two's complement
// - Unsigned divide zero-extends low 32 operand bits
// - Divides never overflow; zero divisor gives anything
// - Quotient to low register, remainder to high
// - Pipeline supplies sign-extended 32-bit divide operands
// - 64-bit mode results sign-extended from bit 31
// - Two instructions between result read and write
// - Multiply-add multiplies low 16 bits signed
// - Product plus 64-bit low register; high undefined
// - Multiply-add never raises integer overflow
// - Multiply-add outside 64-bit mode is reserved
// - Multiply-add waits 4, 36, 68 cycles
// - Multiply-add waits 1, 2, 0 cycles
`ifndef DMU_MAP_SVH
`define DMU_MAP_SVH
`define DMU_OPC_MSB        31
`define DMU_OPC_LSB        26
`define DMU_FS_MSB         25
`define DMU_FS_LSB         21
`define DMU_SS_MSB         20
`define DMU_SS_LSB         16
`define DMU_ZERO_MSB       15
`define DMU_ZERO_LSB       6
`define DMU_FUNC_MSB       5
`define DMU_FUNC_LSB       0
`define DMU_OPC_SPECIAL    6'h00
`define DMU_FUNC_DIV       6'h1A
`define DMU_FUNC_UNSIGNED_WORD_DIVIDE      6'h1B
`define DMU_FUNC_DWORD_MUL_ADD_16   6'h29
`define DMU_WAIT_MUL32     7'h01
`define DMU_WAIT_DMUL      7'h04
`define DMU_WAIT_DIV32     7'h24
`define DMU_WAIT_SIGNED_DWORD_DIVIDE      7'h44
`define DMU_WAIT_READ      7'h02
`define DMU_WAIT_MADD      7'h00
`endif

// *** rtl/dmu_pkg.sv ***
package dmu_pkg;
   typedef enum logic [2:0] {
      DMU_OP_NONE = 3'h0,
      DMU_OP_MUL32 = 3'h1,
      DMU_OP_DMUL = 3'h2,
      DMU_OP_DIV32 = 3'h3,
      DMU_OP_SIGNED_DWORD_DIVIDE = 3'h4,
      DMU_OP_READ = 3'h5,
      DMU_OP_MADD = 3'h6
   } dmu_prior_t;
   typedef enum logic [1:0] {
      DMU_ST_IDLE = 2'h0,
      DMU_ST_BUSY = 2'h1
   } dmu_state_t;
endpackage

// *** rtl/dmu_if.sv ***
`timescale 1ns/100ps
interface dmu_if;
   logic        issue;
   logic [31:0] instr;
   logic [63:0] first_src;
   logic [63:0] second_src;
   logic        mode64;
   logic [2:0]  prior_op;
   logic        accepted;
   logic        reserved_exc;
   logic        busy;
   logic        done;
   logic [63:0] low_result_reg;
   logic [63:0] high_result_reg;
   modport unit (input issue, instr, first_src, second_src, mode64, prior_op,
                 output accepted, reserved_exc, busy, done, low_result_reg,
                 high_result_reg);
   modport pipe (output issue, instr, first_src, second_src, mode64, prior_op,
                 input accepted, reserved_exc, busy, done, low_result_reg,
                 high_result_reg);
endinterface

// *** rtl/dmu_unit.sv ***
`timescale 1ns/100ps
`include "dmu_map.svh"
module dmu_unit (
   input  wire logic clock_in,
   input  wire logic resetn_in,
   dmu_if.unit       bus
);
   typedef enum logic [1:0] {
      DMU_K_NONE = 2'h0,
      DMU_K_DIV = 2'h1,
      DMU_K_UNSIGNED_WORD_DIVIDE = 2'h2,
      DMU_K_MADD = 2'h3
   } dmu_kind_t;

   function automatic dmu_kind_t dmu_decode(input logic [31:0] w);
      dmu_decode = DMU_K_NONE;
      if (w[`DMU_OPC_MSB:`DMU_OPC_LSB] == `DMU_OPC_SPECIAL &&
          w[`DMU_ZERO_MSB:`DMU_ZERO_LSB] == 10'h000) begin
         case (w[`DMU_FUNC_MSB:`DMU_FUNC_LSB])
            `DMU_FUNC_DIV:     dmu_decode = DMU_K_DIV;
            `DMU_FUNC_UNSIGNED_WORD_DIVIDE:    dmu_decode = DMU_K_UNSIGNED_WORD_DIVIDE;
            `DMU_FUNC_DWORD_MUL_ADD_16: dmu_decode = DMU_K_MADD;
            default:           dmu_decode = DMU_K_NONE;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   dmu_kind_t   kind;
   logic [31:0] a32;
   logic [31:0] b32;
   logic [31:0] q32;
   logic [31:0] r32;
   logic [31:0] prod32;
   logic [63:0] prod;
   logic [63:0] lo_q;
   logic [63:0] hi_q;
   logic        acc_q;
   logic        exc_q;
   logic        done_q;
   logic        busy_q;

   assign kind = bus.issue ? dmu_decode(bus.instr) : DMU_K_NONE;
   assign a32  = bus.first_src[31:0];
   assign b32  = bus.second_src[31:0];

   always_comb begin
      q32 = 32'h0000_0000;
      r32 = 32'h0000_0000;
      if (b32 == 32'h0000_0000) begin
         // Zero divisor: results are free, avoid a divide by zero
         q32 = 32'hFFFF_FFFF;
         r32 = a32;
      end else if (kind == DMU_K_DIV) begin
         q32 = 32'($signed(a32) / $signed(b32));
         r32 = 32'($signed(a32) % $signed(b32));
      end else begin
         q32 = a32 / b32;
         r32 = a32 % b32;
      end
   end

   // Only low 16 bits used; bad sign extension above gives a free result
   // Product sized at 32 bits first so no tool trims it to 16, then widened by sign
   assign prod32 = $signed(bus.first_src[15:0]) * $signed(bus.second_src[15:0]);
   assign prod   = {{32{prod32[31]}}, prod32};

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lo_q <= 64'h0;
         hi_q <= 64'h0;
      end else if (kind == DMU_K_DIV || kind == DMU_K_UNSIGNED_WORD_DIVIDE) begin
         lo_q <= {{32{q32[31]}}, q32};
         hi_q <= {{32{r32[31]}}, r32};
      end else if (kind == DMU_K_MADD && bus.mode64) begin
         lo_q <= lo_q + prod;
         hi_q <= 64'h0;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         acc_q  <= 1'b0;
         exc_q  <= 1'b0;
         done_q <= 1'b0;
      end else begin
         acc_q  <= kind != DMU_K_NONE;
         exc_q  <= kind == DMU_K_MADD && !bus.mode64;
         done_q <= kind == DMU_K_DIV || kind == DMU_K_UNSIGNED_WORD_DIVIDE ||
                   (kind == DMU_K_MADD && bus.mode64);
      end
   end

   // One-cycle datapath; busy covers the result write cycle
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= kind == DMU_K_DIV || kind == DMU_K_UNSIGNED_WORD_DIVIDE ||
                   (kind == DMU_K_MADD && bus.mode64);
      end
   end

   assign bus.accepted        = acc_q;
   assign bus.reserved_exc    = exc_q;
   assign bus.done            = done_q;
   assign bus.busy            = busy_q;
   assign bus.low_result_reg  = lo_q;
   assign bus.high_result_reg = hi_q;
endmodule // dmu_unit

// *** rtl/dmu_pipe.sv ***
`timescale 1ns/100ps
`include "dmu_map.svh"
module dmu_pipe (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        req_in,
   input  wire logic [31:0] instr_in,
   input  wire logic [63:0] first_src_in,
   input  wire logic [63:0] second_src_in,
   input  wire logic        mode64_in,
   input  wire logic [2:0]  note_op_in,
   output logic             req_ready_out,
   output logic             done_out,
   output logic             exc_out,
   output logic [63:0]      low_out,
   output logic [63:0]      high_out,
   dmu_if.pipe              bus
);
   dmu_pkg::dmu_state_t state_q;
   logic [6:0]  wait_q;
   logic [6:0]  need;
   logic        is_madd;
   logic        is_write;
   logic        go;
   logic        iss_q;
   logic [31:0] ins_q;
   logic [63:0] fs_q;
   logic [63:0] ss_q;
   logic        m64_q;

   function automatic logic [6:0] dmu_wait(input logic [2:0] op);
      case (dmu_pkg::dmu_prior_t'(op))
         dmu_pkg::DMU_OP_MUL32: dmu_wait = `DMU_WAIT_MUL32;
         dmu_pkg::DMU_OP_READ:  dmu_wait = `DMU_WAIT_READ;
         dmu_pkg::DMU_OP_MADD:  dmu_wait = `DMU_WAIT_MADD;
         dmu_pkg::DMU_OP_DMUL:  dmu_wait = `DMU_WAIT_DMUL;
         dmu_pkg::DMU_OP_DIV32: dmu_wait = `DMU_WAIT_DIV32;
         dmu_pkg::DMU_OP_SIGNED_DWORD_DIVIDE:  dmu_wait = `DMU_WAIT_SIGNED_DWORD_DIVIDE;
         default:               dmu_wait = 7'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   assign is_madd  = instr_in[`DMU_FUNC_MSB:`DMU_FUNC_LSB] == `DMU_FUNC_DWORD_MUL_ADD_16;
   assign is_write = is_madd ||
                     instr_in[`DMU_FUNC_MSB:`DMU_FUNC_LSB] == `DMU_FUNC_DIV ||
                     instr_in[`DMU_FUNC_MSB:`DMU_FUNC_LSB] == `DMU_FUNC_UNSIGNED_WORD_DIVIDE;
   // Any writer waits out the prior read too, so no earlier value is lost
   assign go = req_in && state_q == dmu_pkg::DMU_ST_IDLE && !bus.busy &&
               !(is_write && wait_q != 7'h00);

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wait_q <= 7'h00;
      end else if (note_op_in != 3'h0 && dmu_wait(note_op_in) > wait_q) begin
         wait_q <= dmu_wait(note_op_in);
      end else if (wait_q != 7'h00) begin
         wait_q <= wait_q - 7'h01;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= dmu_pkg::DMU_ST_IDLE;
      end else begin
         case (state_q)
            dmu_pkg::DMU_ST_IDLE: if (go) state_q <= dmu_pkg::DMU_ST_BUSY;
            dmu_pkg::DMU_ST_BUSY: if (bus.accepted || !iss_q) state_q <= dmu_pkg::DMU_ST_IDLE;
            default:              state_q <= dmu_pkg::DMU_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         iss_q <= 1'b0;
         ins_q <= 32'h0000_0000;
         fs_q  <= 64'h0;
         ss_q  <= 64'h0;
         m64_q <= 1'b0;
      end else begin
         iss_q <= go;
         if (go) begin
            ins_q <= instr_in;
            // Divide operands arrive sign-extended from bit 31
            fs_q  <= first_src_in;
            ss_q  <= second_src_in;
            m64_q <= mode64_in;
         end
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         req_ready_out <= 1'b0;
         done_out      <= 1'b0;
         exc_out       <= 1'b0;
         low_out       <= 64'h0;
         high_out      <= 64'h0;
      end else begin
         req_ready_out <= state_q == dmu_pkg::DMU_ST_IDLE && !go;
         done_out      <= bus.done;
         exc_out       <= bus.reserved_exc;
         low_out       <= bus.low_result_reg;
         high_out      <= bus.high_result_reg;
      end
   end

   assign bus.issue      = iss_q;
   assign bus.instr      = ins_q;
   assign bus.first_src  = fs_q;
   assign bus.second_src = ss_q;
   assign bus.mode64     = m64_q;
   assign bus.prior_op   = 3'h0;
endmodule // dmu_pipe

// *** bench/dmu_asserts.sv ***
`timescale 1ns/100ps
module dmu_asserts (
   input wire logic        clock_in,
   input wire logic        resetn_in,
   input wire logic        issue,
   input wire logic [31:0] instr,
   input wire logic [63:0] first_src,
   input wire logic [63:0] second_src,
   input wire logic        mode64,
   input wire logic        accepted,
   input wire logic        reserved_exc,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [63:0] low_result_reg,
   input wire logic [63:0] high_result_reg
);
   logic               fmt_ok;
   logic               is_div;
   logic               is_madd;
   logic signed [63:0] prod;
   // Both divides share func bits 5:1; bit 0 only picks signedness
   assign fmt_ok  = instr[31:26] == 6'h00 && instr[15:6] == 10'h000;
   assign is_div  = fmt_ok && instr[5:1] == 5'h0D;
   assign is_madd = fmt_ok && instr[5:0] == 6'h29;
   assign prod    = $signed(first_src[15:0]) * $signed(second_src[15:0]);
   ////////////////////////////////////////////////////////////
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (!resetn_in);
   a_decode_accept: assert property (
      issue && (is_div || (is_madd && mode64)) |=> accepted && done)
      else $error("decoded op not accepted");
   a_refuse_other: assert property (issue && !fmt_ok |=> !accepted && !done)
      else $error("bad format accepted");
   a_madd_reserved: assert property (
      issue && is_madd && !mode64 |=> reserved_exc && !done)
      else $error("madd outside 64-bit mode not refused");
   a_madd_sum: assert property (
      issue && is_madd && mode64 |=>
      low_result_reg == $past(low_result_reg) + $past(prod) && !reserved_exc)
      else $error("madd sum wrong");
   a_div_sext: assert property (
      issue && is_div && mode64 |=> low_result_reg[63:32] == {32{low_result_reg[31]}}
      && high_result_reg[63:32] == {32{high_result_reg[31]}})
      else $error("divide result not sign-extended");
   a_div_no_exc: assert property (issue && is_div |=> !reserved_exc)
      else $error("divide raised exception");
   a_busy_span: assert property (busy |-> $past(issue) && done)
      else $error("busy without issued op");
   // Results must not drift between writes, or a later madd adds garbage
   a_result_hold: assert property (
      !done |-> $stable(low_result_reg) && $stable(high_result_reg))
      else $error("result changed without done");
endmodule // dmu_asserts

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_top;
   logic        clock_in, resetn_in, req_in, mode64_in, req_ready_out, done_out, exc_out;
   logic [2:0]  note_op_in;
   logic [31:0] instr_in, seed, k;
   logic [63:0] first_src_in, second_src_in, low_out, high_out, exp_lo;
   int          err_count, n_checks, cyc, lat;
   int          wt[6] = '{1, 4, 36, 68, 2, 0};
   dmu_if bus_if ();
   dmu_unit dmu_unit_inst (.clock_in(clock_in), .resetn_in(resetn_in), .bus(bus_if));
   dmu_pipe dmu_pipe_inst (.clock_in(clock_in), .resetn_in(resetn_in), .req_in(req_in),
      .instr_in(instr_in), .first_src_in(first_src_in), .second_src_in(second_src_in),
      .mode64_in(mode64_in), .note_op_in(note_op_in), .req_ready_out(req_ready_out),
      .done_out(done_out), .exc_out(exc_out), .low_out(low_out), .high_out(high_out),
      .bus(bus_if));
   dmu_asserts dmu_asserts_inst (.clock_in(clock_in), .resetn_in(resetn_in),
      .issue(bus_if.issue), .instr(bus_if.instr), .first_src(bus_if.first_src),
      .second_src(bus_if.second_src), .mode64(bus_if.mode64), .accepted(bus_if.accepted),
      .reserved_exc(bus_if.reserved_exc), .busy(bus_if.busy), .done(bus_if.done),
      .low_result_reg(bus_if.low_result_reg), .high_result_reg(bus_if.high_result_reg));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [63:0] sx(input logic [31:0] v);
      return {{32{v[31]}}, v};
   endfunction
   function automatic logic [63:0] s16(input logic [31:0] v);
      return {{48{v[15]}}, v[15:0]};
   endfunction
   task automatic conclude();
      if (err_count == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Holds the request until the issue strobe shows; lat is the wait seen
   task automatic run(input logic [5:0] fn, input logic [63:0] a, b, input logic m,
                      input logic [9:0] z);
      logic [63:0]        q;
      logic [63:0]        r;
      logic signed [63:0] p;
      int                 n;
      instr_in = {6'h00, 5'h03, 5'h04, z, fn};
      first_src_in = a;
      second_src_in = b;
      mode64_in = m;
      req_in = 1'b1;
      lat = 0;
      n = 0;
      do begin
         @(negedge clock_in);
         lat++;
      end while (bus_if.issue !== 1'b1 && lat < 200);
      `CHK(req_ready_out, 1'b0)
      req_in = 1'b0;
      while (done_out !== 1'b1 && exc_out !== 1'b1 && n < 300) begin
         @(negedge clock_in);
         n++;
      end
      p = $signed(a[15:0]) * $signed(b[15:0]);
      if (fn[0]) begin
         q = sx(a[31:0] / b[31:0]);
         r = sx(a[31:0] % b[31:0]);
      end else begin
         q = sx($signed(a[31:0]) / $signed(b[31:0]));
         r = sx($signed(a[31:0]) % $signed(b[31:0]));
      end
      if (z != 10'h000) begin
         `CHK(bus_if.low_result_reg, exp_lo)
      end else if (fn == 6'h29 && !m) begin
         `CHK({exc_out, bus_if.low_result_reg}, {1'b1, exp_lo})
      end else if (fn == 6'h29) begin
         exp_lo = exp_lo + p;
         `CHK({exc_out, low_out}, {1'b0, exp_lo})
      end else begin
         `CHK({exc_out, done_out}, 2'b01)
         // Zero divisor: all-ones quotient is the chosen filler value
         exp_lo = (b[31:0] == 32'h0) ? 64'hFFFFFFFFFFFFFFFF : q;
         if (b[31:0] != 32'h0) `CHK({low_out, high_out}, {q, r})
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         conclude();
      end
   end
   initial begin
      seed = 32'h88F1;
      resetn_in = 1'b0;
      req_in = 1'b0;
      mode64_in = 1'b1;
      note_op_in = 3'h0;
      instr_in = 32'h0;
      first_src_in = 64'h0;
      second_src_in = 64'h0;
      exp_lo = 64'h0;
      repeat (2) @(negedge clock_in);
      resetn_in = 1'b1;
      run(6'h1B, sx(32'hFFFFFFF0), sx(32'h00000003), 1'b1, 10'h000);
      run(6'h1A, sx(32'hFFFFFFF9), sx(32'h00000002), 1'b1, 10'h000);
      repeat (40) begin
         k = rnd();
         if (k[6]) run(6'h29, s16(rnd()), s16(rnd()), 1'b1, 10'h000);
         else run({5'h0D, k[5]}, sx(rnd()), sx((rnd() >> k[4:0]) | 32'h1), k[7], 10'h000);
      end
      foreach (wt[i]) begin
         note_op_in = 3'(i + 1);
         @(negedge clock_in);
         note_op_in = 3'h0;
         `CHK(req_ready_out, 1'b1)
         run(6'h29, s16(rnd()), s16(rnd()), 1'b1, 10'h000);
         `CHK(lat > wt[i] && lat <= wt[i] + 4, 1'b1)
      end
      run(6'h29, s16(rnd()), s16(rnd()), 1'b0, 10'h000);
      run(6'h1A, sx(rnd()), 64'h0, 1'b1, 10'h000);
      // Bad format last: a refused op raises neither done nor exc, so run waits out its 300-cycle limit
      run(6'h1A, sx(rnd()), 64'h3, 1'b1, 10'h001);
      conclude();
   end
endmodule // tb_top
